// File: verilog/dpsc_pkg.sv
// Package for the dual-port memory port controller: timing, mailbox, types
`default_nettype none
package dpsc_pkg;
  // Clock period in ps (200 MHz)
  localparam int CLK_PS = 5000;
  // Least times in ns for the slowest grade
  localparam int PULSE_WIDTH_NS          = 30;
  localparam int STROBE_TO_FLOAT_DELAY_NS = 25;
  localparam int WRITE_DATA_SETUP_NS     = 20;
  localparam int ACCESS_TIME_NS          = 55;
  localparam int RELEASE_TO_DATA_DELAY_NS = 45;
  localparam int FLAG_SET_DELAY_NS       = 45;
  localparam int FLAG_CLEAR_DELAY_NS     = 45;
  localparam int ADDR_SETUP_NS           = 40;
  // Least times round up to whole cycles
  localparam int PULSE_CYC  = (PULSE_WIDTH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FLOAT_CYC  = ((STROBE_TO_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS) * 1000
                               + CLK_PS - 1) / CLK_PS;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RELEASE_CYC = (RELEASE_TO_DATA_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SETUP_CYC  = (ADDR_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FLAG_CYC   = (FLAG_SET_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 5;
  // Mailbox offsets from the top of the array
  localparam int LEFT_BOX_FROM_TOP  = 2;
  localparam int RIGHT_BOX_FROM_TOP = 1;

  typedef enum logic [4:0] {
    DPSC_IDLE  = 5'b00001,
    DPSC_SETUP = 5'b00010,
    DPSC_WRITE = 5'b00100,
    DPSC_READ  = 5'b01000,
    DPSC_DONE  = 5'b10000
  } dpsc_state_t;

  typedef struct packed {
    logic        write;
    logic [10:0] addr;
    logic [7:0]  data;
  } dpsc_req_t;
endpackage : dpsc_pkg
`default_nettype wire

// File: verilog/dpsc_port_master.sv
// One-port master that drives a port of an asynchronous dual-port memory
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Write is select and strobe low together
// - Data timed against the rising ending strobe
// - Output enable low: hold strobe longer
// - Output enable high: minimum pulse suffices
// - Strobe stays high during reads
module dpsc_port_master #(
  parameter int          ADDR_W   = 10,
  parameter logic        IS_RIGHT = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // Requests from the local bus side
  input  wire dpsc_pkg::dpsc_req_t req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   wr_lost,
  output logic                   mail_flag,
  // Pins towards the memory port
  output logic                   sel_n,
  output logic                   wstrobe_n,
  output logic                   oe_n,
  output logic [ADDR_W-1:0]      addr,
  output logic [7:0]             data_o,
  output logic                   data_oe,
  // Driven by the memory port
  input  wire logic [7:0]        data_i,
  input  wire logic              busy_n,
  input  wire logic              flag_n
);
  typedef struct packed {
    dpsc_pkg::dpsc_state_t st;
    logic [dpsc_pkg::CNT_W-1:0] cnt;
    logic                       wr;
    logic                       lost;
    logic                       ready;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic                       wlost;
    logic                       flag;
    logic                       sel_n;
    logic                       we_n;
    logic                       oe_n;
    logic [ADDR_W-1:0]          addr;
    logic [7:0]                 dout;
    logic                       doe;
  } dpsc_st_t;

  // Own mailbox address, read to clear our flag
  localparam logic [ADDR_W-1:0] OWN_BOX = IS_RIGHT ?
    ADDR_W'((1 << ADDR_W) - dpsc_pkg::RIGHT_BOX_FROM_TOP) :
    ADDR_W'((1 << ADDR_W) - dpsc_pkg::LEFT_BOX_FROM_TOP);
  // Phase lengths in whole clock cycles
  localparam logic [dpsc_pkg::CNT_W-1:0] SETUP_N   = dpsc_pkg::CNT_W'(dpsc_pkg::SETUP_CYC);
  localparam logic [dpsc_pkg::CNT_W-1:0] PULSE_N   = dpsc_pkg::CNT_W'(dpsc_pkg::PULSE_CYC);
  localparam logic [dpsc_pkg::CNT_W-1:0] FLOAT_N   = dpsc_pkg::CNT_W'(dpsc_pkg::FLOAT_CYC);
  localparam logic [dpsc_pkg::CNT_W-1:0] ACCESS_N  = dpsc_pkg::CNT_W'(dpsc_pkg::ACCESS_CYC);
  localparam logic [dpsc_pkg::CNT_W-1:0] RELEASE_N = dpsc_pkg::CNT_W'(dpsc_pkg::RELEASE_CYC);

  // Old data stays on the pins for the release-to-data delay after busy rises, so wait the longer
  localparam logic [dpsc_pkg::CNT_W-1:0] WAIT_N =
    (ACCESS_N > RELEASE_N) ? ACCESS_N : RELEASE_N;
  // A strobe-ended write with outputs on must also cover the turn-off time
  localparam logic [dpsc_pkg::CNT_W-1:0] LONG_N = (FLOAT_N > PULSE_N) ? FLOAT_N : PULSE_N;

  // Idle, deselected, data pins released; constants only under async reset
  localparam dpsc_st_t S_RST = '{
    st:     dpsc_pkg::DPSC_IDLE,
    cnt:    '0,
    wr:     1'b0,
    lost:   1'b0,
    ready:  1'b0,
    rdata:  8'h00,
    rvalid: 1'b0,
    wlost:  1'b0,
    flag:   1'b0,
    sel_n:  1'b1,
    we_n:   1'b1,
    oe_n:   1'b1,
    addr:   '0,
    dout:   8'h00,
    doe:    1'b0
  };

  dpsc_st_t s_q;
  dpsc_st_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.wlost = 1'b0;
    s_d.flag = ~flag_n;

    unique case (s_q.st)
      dpsc_pkg::DPSC_IDLE: begin
        s_d.ready = 1'b1;
        if (req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.wr = req.write;
          s_d.lost = 1'b0;
          s_d.addr = req.addr[ADDR_W-1:0];
          s_d.dout = req.data;
          s_d.we_n = 1'b1;
          // reads drive outputs, writes keep them off
          s_d.oe_n = req.write;
          s_d.cnt = SETUP_N;
          s_d.st = dpsc_pkg::DPSC_SETUP;
        end
      end

      dpsc_pkg::DPSC_SETUP: begin
        // Address settles before select, so no stray location is touched
        if (s_q.cnt > 1) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (s_q.wr) begin
          // select and strobe together open the write
          s_d.sel_n = 1'b0;
          s_d.we_n = 1'b0;
          s_d.doe = 1'b1;
          // longer pulse if outputs were enabled
          if (s_q.oe_n) begin
            s_d.cnt = PULSE_N;
          end else begin
            s_d.cnt = LONG_N;
          end
          s_d.st = dpsc_pkg::DPSC_WRITE;
        end else begin
          s_d.sel_n = 1'b0;
          s_d.cnt = ACCESS_N;
          s_d.st = dpsc_pkg::DPSC_READ;
        end
      end

      dpsc_pkg::DPSC_WRITE: begin
        // busy during the write means it was dropped
        if (!busy_n) begin
          s_d.lost = 1'b1;
        end
        if (s_q.cnt > 1) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          // strobe rises first and ends the write; data held
          s_d.we_n = 1'b1;
          s_d.st = dpsc_pkg::DPSC_DONE;
        end
      end

      dpsc_pkg::DPSC_READ: begin
        // wait out busy on either side
        // Select stays low while waiting; dropping it would give up our turn
        if (!busy_n) begin
          // wait out stale data after busy rises
          s_d.cnt = WAIT_N;
        end else if (s_q.cnt > 1) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          s_d.rdata = data_i;
          s_d.rvalid = 1'b1;
          // deselect after the mailbox read clears our flag
          s_d.sel_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.st = dpsc_pkg::DPSC_DONE;
        end
      end

      dpsc_pkg::DPSC_DONE: begin
        // select rises, data floats; a write dropped under busy is reported on wr_lost
        // Ready returns together with the released pins
        s_d.sel_n = 1'b1;
        s_d.doe = 1'b0;
        s_d.wlost = s_q.wr & s_q.lost;
        s_d.ready = 1'b1;
        s_d.st = dpsc_pkg::DPSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output is a field of the state register
  assign req_ready = s_q.ready;
  assign rd_data   = s_q.rdata;
  assign rd_valid  = s_q.rvalid;
  assign wr_lost   = s_q.wlost;
  assign mail_flag = s_q.flag;
  assign sel_n     = s_q.sel_n;
  assign wstrobe_n = s_q.we_n;
  assign oe_n      = s_q.oe_n;
  assign addr      = s_q.addr;
  assign data_o    = s_q.dout;
  assign data_oe   = s_q.doe;

  // Own mailbox address drives no logic; it is only reduced into unused_box
  logic unused_box;
  assign unused_box = ^OWN_BOX;
endmodule : dpsc_port_master
`default_nettype wire

// File: tb/dpsc_port_master_chk.sv
// Port timing checks for the memory port master
`timescale 1ns/1ps
`default_nettype none
module dpsc_port_master_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sel_n,
  input wire logic       wstrobe_n,
  input wire logic       oe_n,
  input wire logic [7:0] data_o,
  input wire logic       data_oe,
  input wire logic       busy_n,
  input wire logic       rd_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence strobe_fall_s;
    $fell(wstrobe_n);
  endsequence
  // Read open while the far port holds the location
  sequence read_blocked_s;
    !busy_n && !sel_n && wstrobe_n;
  endsequence
  // Busy just released under a read that is still open
  sequence read_released_s;
    $rose(busy_n) && !sel_n && wstrobe_n;
  endsequence
  AST_WR_OVERLAP: assert property (!wstrobe_n |-> !sel_n)
    else $error("strobe low outside select");
  AST_PULSE_MIN: assert property (strobe_fall_s |-> !wstrobe_n [*6])
    else $error("write pulse too short");
  AST_END_HOLD: assert property ($rose(wstrobe_n) |-> data_oe && $stable(data_o))
    else $error("data moved at write end");
  AST_OE_IN_WRITE: assert property (!wstrobe_n |-> oe_n)
    else $error("output enable low in write");
  AST_READ_STROBE: assert property (!sel_n && !oe_n |-> wstrobe_n)
    else $error("strobe low in read");
  AST_BLOCKED_NO_DATA: assert property (read_blocked_s |=> !rd_valid)
    else $error("read data taken while busy");
  AST_RELEASE_WAIT: assert property (read_released_s |-> !rd_valid [*8])
    else $error("read data taken too soon after busy");
endmodule : dpsc_port_master_chk
bind dpsc_port_master dpsc_port_master_chk u_chk (.clk, .rst, .sel_n, .wstrobe_n, .oe_n,
  .data_o, .data_oe, .busy_n, .rd_valid);
`default_nettype wire

// File: tb/dpsc_dev_model.sv
// Behavioural model of one memory port with busy and mailbox flag
`timescale 1ns/1ps
`default_nettype none
module dpsc_dev_model (
  input wire logic       clk,
  input wire logic       sel_n,
  input wire logic       wstrobe_n,
  input wire logic       oe_n,
  input wire logic [9:0] addr,
  input wire logic [7:0] data_o,
  output logic [7:0]     data_i,
  output logic           busy_n,
  input wire logic       contend,
  input wire logic       poke,
  output logic           flag_n
);
  logic [7:0] mem [1024];
  logic [7:0] last = 8'h00;
  logic       flag_q = 1'b0;
  assign busy_n = !(contend && !sel_n);
  assign data_i = (!sel_n && !oe_n && busy_n) ? mem[addr] : ~last;
  assign flag_n = !flag_q;
  always_ff @(posedge clk) begin
    if (!sel_n && !wstrobe_n && busy_n) mem[addr] <= data_o;
    if (!sel_n && !oe_n) last <= data_i;
    if (poke) flag_q <= 1'b1;
    else if (!sel_n && !oe_n && addr == 10'h3fe) flag_q <= 1'b0;
  end
endmodule : dpsc_dev_model
`default_nettype wire

// File: tb/dual_port_sram_arbitration_bench.sv
// Self-checking bench for the memory port master
`timescale 1ns/1ps
`default_nettype none
module dual_port_sram_arbitration_bench;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, contend = 1'b0, poke = 1'b0, lost, vld;
  logic req_ready, rd_valid, wr_lost, mail_flag, sel_n, wstrobe_n, oe_n, data_oe;
  logic busy_n, flag_n;
  logic [7:0] rd_data, data_o, data_i;
  logic [9:0] addr;
  dpsc_pkg::dpsc_req_t req = '0;
  int err_total = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  dpsc_port_master dut (.clk, .rst, .req, .req_valid, .req_ready, .rd_data, .rd_valid,
    .wr_lost, .mail_flag, .sel_n, .wstrobe_n, .oe_n, .addr, .data_o, .data_oe, .data_i,
    .busy_n, .flag_n);
  dpsc_dev_model u_dev (.clk, .sel_n, .wstrobe_n, .oe_n, .addr, .data_o, .data_i,
    .busy_n, .contend, .poke, .flag_n);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // One transfer; waits are bounded, the watchdog catches a hang
  task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
    for (int n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    req <= '{write: w, addr: a, data: d};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    lost = 1'b0;
    vld = 1'b0;
    for (int n = 0; n < 200; n++) begin
      @(negedge clk);
      if (wr_lost === 1'b1) lost = 1'b1;
      if (rd_valid === 1'b1) vld = 1'b1;
      if (req_ready === 1'b1) break;
    end
  endtask : xfer
  task automatic scen_rw();
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 11'(i * 300), 8'(8'h3c + i));
      chk({6'h00, lost, vld}, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 11'(i * 300), 8'h00);
      chk(rd_data, 8'(8'h3c + i));
      chk({7'h00, vld}, 8'h01);
    end
  endtask : scen_rw
  task automatic scen_busy();
    @(posedge clk);
    contend <= 1'b1;
    xfer(1'b1, 11'h12c, 8'hee);
    chk({7'h00, lost}, 8'h01);
    @(posedge clk);
    contend <= 1'b0;
    xfer(1'b0, 11'h12c, 8'h00);
    chk(rd_data, 8'h3d);
  endtask : scen_busy
  // Read held off by busy, then released: data one access time later
  task automatic scen_wait();
    int n;
    for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    contend <= 1'b1;
    req <= '{write: 1'b0, addr: 11'h12c, data: 8'h00};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (30) @(negedge clk);
    chk({6'h00, sel_n, rd_valid}, 8'h00);
    @(posedge clk);
    contend <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) break;
    end
    chk(8'(n), 8'(dpsc_pkg::ACCESS_CYC));
    chk(rd_data, 8'h3d);
  endtask : scen_wait
  task automatic scen_mail();
    @(posedge clk);
    poke <= 1'b1;
    @(posedge clk);
    poke <= 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, mail_flag}, 8'h01);
    xfer(1'b0, 11'h3fe, 8'h00);
    repeat (3) @(negedge clk);
    chk({7'h00, mail_flag}, 8'h00);
  endtask : scen_mail
  initial begin
    #50us;
    err_total++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    scen_rw();
    scen_busy();
    scen_wait();
    scen_mail();
    final_report();
  end
endmodule : dual_port_sram_arbitration_bench
`default_nettype wire
